// ===== wff_core.sv
// Receive address filter and wake frame detector
`timescale 1ns/1ps
`include "wff_defines.svh"
module wff_core
	import wff_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Station address
	input wire logic [15:0] station_addr_high,
	input wire logic [31:0] station_addr_low,
	// Filter mode
	input wire logic pass_all_multicast,
	input wire logic promiscuous_mode_bit,
	input wire logic inverse_filter,
	// Wake control
	input wire logic wake_frame_enable,
	input wire logic wake_clear,
	// Pattern table access
	input wire logic filt_wr,
	input wire logic filt_rd,
	input wire logic [31:0] filt_wdata,
	output logic [31:0] filt_rdata,
	output logic filt_rvalid,
	// Receive byte stream in
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [7:0] rx_data,
	// Receive byte stream out
	output logic out_valid,
	output logic out_sof,
	output logic out_eof,
	output logic [7:0] out_data,
	output logic out_accept,
	output logic out_reject,
	output logic out_multicast,
	// Wake status
	output logic wake_frame_received,
	output logic [7:0] wake_match_filters,
	output logic remote_wakeup,
	output logic fully_operational
);
	wff_tab_if tab ();

	wff_table u_table (
		.clk(clk),
		.rst(rst),
		.tab(tab)
	);

	// ****************************************
	// Byte position and table access
	// ****************************************
	logic [`WFF_POS_W-1:0] pos_cnt;
	logic [`WFF_POS_W-1:0] cur_pos;

	assign cur_pos = rx_sof ? '0 : pos_cnt;
	assign tab.pos = cur_pos;
	assign tab.wr = filt_wr;
	assign tab.rd = filt_rd;
	assign tab.wdata = filt_wdata;
	assign filt_rdata = tab.rdata;
	assign filt_rvalid = tab.rvalid;

	// Position saturates so long frames never wrap back into a pattern window
	always_ff @(posedge clk) begin
		if (rst) begin
			pos_cnt <= '0;
		end else if (rx_valid) begin
			if (rx_eof) begin
				pos_cnt <= '0;
			end else if (cur_pos != `WFF_POS_MAX) begin
				pos_cnt <= cur_pos + 9'h001;
			end else begin
				pos_cnt <= cur_pos;
			end
		end
	end

	// ****************************************
	// Stage one: byte aligned with the table select
	// ****************************************
	logic d1_valid;
	logic d1_sof;
	logic d1_eof;
	logic [7:0] d1_data;
	logic [`WFF_POS_W-1:0] d1_pos;

	always_ff @(posedge clk) begin
		if (rst) begin
			d1_valid <= 1'b0;
			d1_sof <= 1'b0;
			d1_eof <= 1'b0;
			d1_data <= '0;
			d1_pos <= '0;
		end else begin
			d1_valid <= rx_valid;
			d1_sof <= rx_valid && rx_sof;
			d1_eof <= rx_valid && rx_eof;
			d1_data <= rx_data;
			d1_pos <= cur_pos;
		end
	end

	// ****************************************
	// Destination address capture
	// ****************************************
	wff_rx_state_type st;
	wff_rx_state_type next_st;
	logic [47:0] da;
	logic [47:0] station;
	logic addr_hit;
	logic is_mc;
	logic da_full;
	logic accept;

	always_comb begin
		next_st = st;
		if (d1_valid) begin
			unique case (st)
				WFF_IDLE, WFF_BODY: begin
					if (d1_sof) begin
						next_st = WFF_ADDR;
					end else if (d1_eof) begin
						next_st = WFF_IDLE;
					end
				end
				WFF_ADDR: begin
					if (d1_pos == `WFF_DA_LAST) begin
						next_st = WFF_BODY;
					end
				end
				default: begin
					next_st = WFF_IDLE;
				end
			endcase
			// Short frames end mid-address and never count as addressed
			if (d1_eof && !(st == WFF_ADDR && d1_pos == `WFF_DA_LAST)) begin
				next_st = WFF_IDLE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= WFF_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			da <= '0;
		end else if (d1_valid && d1_pos <= `WFF_DA_LAST) begin
			da[d1_pos[2:0]*8 +: 8] <= d1_data;
		end
	end

	// First received byte pairs with the low byte of the low register
	assign station = {station_addr_high, station_addr_low}; // RULE_13
	assign addr_hit = (da == station);
	assign is_mc = da[0]; // RULE_14
	// A start byte opens a new frame, so the previous address no longer counts
	assign da_full = !d1_sof && ((st == WFF_BODY)
		|| (st == WFF_ADDR && d1_pos == `WFF_DA_LAST));

	always_comb begin
		accept = 1'b0;
		if (da_full) begin
			if (promiscuous_mode_bit) begin
				accept = 1'b1; // RULE_03
			end else if (pass_all_multicast && is_mc) begin
				accept = 1'b1; // RULE_02
			end else if (inverse_filter) begin
				accept = !addr_hit; // RULE_01
			end else begin
				accept = addr_hit;
			end
		end
	end

	// ****************************************
	// Delivery stage
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_sof <= 1'b0;
			out_eof <= 1'b0;
			out_data <= '0;
		end else begin
			out_valid <= d1_valid && !wake_frame_enable; // RULE_04
			out_sof <= d1_sof && !wake_frame_enable;
			out_eof <= d1_eof && !wake_frame_enable;
			out_data <= d1_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_accept <= 1'b0;
			out_reject <= 1'b0;
			out_multicast <= 1'b0;
		end else begin
			out_accept <= d1_eof && !wake_frame_enable && accept; // RULE_04
			out_reject <= d1_eof && !wake_frame_enable && !accept;
			out_multicast <= d1_eof && !wake_frame_enable && da_full && is_mc;
		end
	end

	// ****************************************
	// Pattern CRC per filter
	// ****************************************
	function automatic wff_crc_type crc_byte(input wff_crc_type c, input logic [7:0] d);
		wff_crc_type r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0} ^ (fb ? `WFF_CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	logic [7:0] hit;

	for (genvar f = 0; f < `WFF_NUM_FILTERS; f++) begin : g_crc
		wff_crc_type crc;
		wff_crc_type base;
		wff_crc_type next_crc;
		assign base = d1_sof ? `WFF_CRC_INIT : crc;
		assign next_crc = tab.incl[f] ? crc_byte(base, d1_data) : base; // RULE_11
		always_ff @(posedge clk) begin
			if (rst) begin
				crc <= `WFF_CRC_INIT;
			end else if (d1_valid) begin
				crc <= next_crc;
			end
		end
		// Filter address check: multicast filters want a group frame, others our own address
		assign hit[f] = d1_eof && da_full && tab.fen[f] && (next_crc == tab.fcrc[f])
			&& (tab.fmc[f] ? is_mc : addr_hit); // RULE_09
	end

	// ****************************************
	// Wake status
	// ****************************************
	logic wake_hit;
	logic wake_en_d;

	assign wake_hit = wake_frame_enable && (hit != 8'h00);

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_frame_received <= `WFF_FLAG_RESET;
		end else if (wake_hit) begin
			wake_frame_received <= 1'b1; // RULE_05 RULE_15
		end else if (wake_clear) begin
			wake_frame_received <= 1'b0; // RULE_15
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wake_match_filters <= '0;
		end else if (wake_hit) begin
			wake_match_filters <= wake_match_filters | hit; // RULE_05
		end else if (wake_clear) begin
			wake_match_filters <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			remote_wakeup <= 1'b0;
		end else begin
			remote_wakeup <= wake_hit; // RULE_05
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wake_en_d <= 1'b0;
		end else begin
			wake_en_d <= wake_frame_enable;
		end
	end

	// Low power only from entering detection until a wake frame or host exit
	always_ff @(posedge clk) begin
		if (rst) begin
			fully_operational <= `WFF_OPER_RESET;
		end else if (wake_hit || !wake_frame_enable) begin
			fully_operational <= 1'b1; // RULE_05
		end else if (!wake_en_d) begin
			fully_operational <= 1'b0; // RULE_04
		end
	end
endmodule // wff_core

// ===== wff_defines.svh
// Constants for the wake frame and address filter block
//
// Function
// RULE_01: Inverse filtering accepts destination addresses unequal to the station address, rejects equal ones.
// RULE_02: With pass_all_multicast set, every multicast frame is accepted in all modes.
// RULE_03: With promiscuous_mode_bit set, every frame is accepted, broadcast included.
// RULE_04: wake_frame_enable enters wake detection; normal delivery stops, data checked against patterns.
// RULE_05: A pattern match sets wake_frame_received, restores full operation, issues remote wakeup.
// RULE_06: Host reads wake status, then clears wake_frame_received and wake_frame_enable.
// RULE_07: Host loads the pattern filter table before enabling wake detection.
// RULE_08: Table holds eight filters; forty sequential writes load it, forty reads return it.
// RULE_09: Wake frame needs frame addressed to the MAC, enabled filter address check, CRC match.
// RULE_10: Each filter's pattern offset sets the first frame byte of its CRC check.
// RULE_11: 128-bit byte mask; byte offset+j is checked only when mask bit j is set.
// RULE_12: The pattern filter table is readable, returning stored words in sequence.
// RULE_13: Station address is the high and low station address registers concatenated.
// RULE_14: First bit of the destination address marks multicast versus physical.
// RULE_15: wake_frame_received stays set until host software clears it.
// RULE_16: Table word pointer advances on each access and wraps after the fortieth word.
`ifndef WFF_DEFINES_SVH
`define WFF_DEFINES_SVH

// ****************************************
// Table geometry
// ****************************************
`define WFF_NUM_FILTERS 8
`define WFF_NUM_WORDS 40
`define WFF_WORD_W 32
`define WFF_PTR_W 6
`define WFF_PTR_LAST 6'h27
`define WFF_MASK_BITS 128
`define WFF_MASK_WORDS 4

// ****************************************
// Word layout of the table
// ****************************************
`define WFF_CTRL_BASE 6'h20
`define WFF_OFF_BASE 6'h22
`define WFF_CRC_BASE 6'h24
`define WFF_EN_BIT 0
`define WFF_MC_BIT 1

// ****************************************
// Frame and CRC constants
// ****************************************
`define WFF_POS_W 9
`define WFF_POS_MAX 9'h1FF
`define WFF_DA_LAST 9'h005
`define WFF_CRC_POLY 16'h8005
`define WFF_CRC_INIT 16'hFFFF
`define WFF_FLAG_RESET 1'b0
`define WFF_OPER_RESET 1'b1

`endif

// ===== wff_pkg.sv
// Types shared by the wake frame and address filter block
package wff_pkg;
	typedef enum logic [1:0] {
		WFF_IDLE = 2'b00,
		WFF_ADDR = 2'b01,
		WFF_BODY = 2'b11
	} wff_rx_state_type;
	typedef logic [15:0] wff_crc_type;
endpackage

// ===== wff_tab_if.sv
// Carrier between the filter core and its pattern table
`timescale 1ns/1ps
`include "wff_defines.svh"
interface wff_tab_if;
	logic wr;
	logic rd;
	logic [`WFF_WORD_W-1:0] wdata;
	logic [`WFF_WORD_W-1:0] rdata;
	logic rvalid;
	logic [`WFF_POS_W-1:0] pos;
	logic [`WFF_NUM_FILTERS-1:0] incl;
	logic [`WFF_NUM_FILTERS-1:0] fen;
	logic [`WFF_NUM_FILTERS-1:0] fmc;
	logic [`WFF_NUM_FILTERS-1:0][15:0] fcrc;
	modport table_side (input wr, input rd, input wdata, input pos,
		output rdata, output rvalid, output incl, output fen, output fmc, output fcrc);
	modport core_side (output wr, output rd, output wdata, output pos,
		input rdata, input rvalid, input incl, input fen, input fmc, input fcrc);
endinterface // wff_tab_if

// ===== wff_table.sv
// Pattern filter table with sequential host access and per-filter byte select
`timescale 1ns/1ps
`include "wff_defines.svh"
module wff_table
	import wff_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core link
	wff_tab_if.table_side tab
);
	logic [`WFF_WORD_W-1:0] words [`WFF_NUM_WORDS];
	logic [`WFF_PTR_W-1:0] ptr;

	// ****************************************
	// Sequential pointer
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr <= '0;
		end else if (tab.wr || tab.rd) begin
			ptr <= (ptr == `WFF_PTR_LAST) ? '0 : ptr + 6'h01; // RULE_16 RULE_08
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < `WFF_NUM_WORDS; i++) begin
				words[i] <= '0;
			end
		end else if (tab.wr) begin
			words[ptr] <= tab.wdata; // RULE_08
		end
	end

	// Write wins over read in a shared cycle; the read still returns the old word
	always_ff @(posedge clk) begin
		if (rst) begin
			tab.rdata <= '0;
			tab.rvalid <= 1'b0;
		end else begin
			tab.rvalid <= tab.rd;
			if (tab.rd) begin
				tab.rdata <= words[ptr]; // RULE_12
			end
		end
	end

	// ****************************************
	// Per-filter byte select
	// ****************************************
	for (genvar f = 0; f < `WFF_NUM_FILTERS; f++) begin : g_filt
		logic [7:0] ctrl;
		logic [7:0] off;
		logic [`WFF_POS_W-1:0] rel;
		logic in_win;
		assign ctrl = words[`WFF_CTRL_BASE + f/4][(f%4)*8 +: 8];
		assign off = words[`WFF_OFF_BASE + f/4][(f%4)*8 +: 8];
		assign tab.fen[f] = ctrl[`WFF_EN_BIT];
		assign tab.fmc[f] = ctrl[`WFF_MC_BIT];
		assign tab.fcrc[f] = words[`WFF_CRC_BASE + f/2][(f%2)*16 +: 16];
		assign rel = tab.pos - {1'b0, off}; // RULE_10
		assign in_win = (tab.pos >= {1'b0, off}) && (rel[8:7] == 2'b00);
		// Registered so the core sees the select beside its delayed byte
		always_ff @(posedge clk) begin
			if (rst) begin
				tab.incl[f] <= 1'b0;
			end else begin
				tab.incl[f] <= tab.fen[f] && in_win && words[f*`WFF_MASK_WORDS + rel[6:5]][rel[4:0]]; // RULE_11
			end
		end
	end
endmodule // wff_table

// ===== wff_core_props.sv
// Port checker for the wake frame and address filter
`timescale 1ns/1ps
module wff_core_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Inputs watched
	input wire logic pass_all_multicast,
	input wire logic promiscuous_mode_bit,
	input wire logic wake_frame_enable,
	input wire logic wake_clear,
	input wire logic filt_rd,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [7:0] rx_data,
	// Outputs watched
	input wire logic filt_rvalid,
	input wire logic out_valid,
	input wire logic out_eof,
	input wire logic [7:0] out_data,
	input wire logic out_accept,
	input wire logic out_reject,
	input wire logic out_multicast,
	input wire logic wake_frame_received,
	input wire logic [7:0] wake_match_filters,
	input wire logic remote_wakeup
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// Length tracker, short frames never pass
	// ****
	logic [2:0] cnt;
	logic [1:0] lng;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 3'h0;
			lng <= 2'h0;
		end else begin
			if (rx_valid)
				cnt <= rx_sof ? 3'h1 : (cnt == 3'h6 ? cnt : cnt + 3'h1);
			lng <= {lng[0], rx_valid && rx_eof && !rx_sof && cnt >= 3'h5};
		end
	end
	property p_delay; out_valid |-> $past(rx_valid, 2) && out_data == $past(rx_data, 2); endproperty
	a_delay: assert property (p_delay) else $error("stream delay wrong");
	property p_quiet; wake_frame_enable && $past(wake_frame_enable) && $past(wake_frame_enable, 2) |-> !out_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("delivery in wake mode");
	property p_verdict; out_accept || out_reject |-> out_eof && out_accept != out_reject; endproperty
	a_verdict: assert property (p_verdict) else $error("bad verdict");
	property p_promisc; out_eof && lng[1] && promiscuous_mode_bit |-> out_accept; endproperty
	a_promisc: assert property (p_promisc) else $error("promiscuous reject");
	property p_mcast; out_eof && lng[1] && out_multicast && pass_all_multicast |-> out_accept; endproperty
	a_mcast: assert property (p_mcast) else $error("multicast reject");
	property p_short; out_eof && !lng[1] |-> out_reject && !remote_wakeup; endproperty
	a_short: assert property (p_short) else $error("short frame passed");
	property p_sticky; wake_frame_received && !wake_clear |=> wake_frame_received; endproperty
	a_sticky: assert property (p_sticky) else $error("wake flag lost");
	property p_cause; remote_wakeup |-> wake_frame_received && wake_match_filters != 8'h00 && lng[1] && $past(wake_frame_enable); endproperty
	a_cause: assert property (p_cause) else $error("wakeup without cause");
	property p_pulse; remote_wakeup |=> !remote_wakeup; endproperty
	a_pulse: assert property (p_pulse) else $error("wakeup not a pulse");
	property p_read; filt_rd |=> filt_rvalid; endproperty
	a_read: assert property (p_read) else $error("read not answered");
endmodule // wff_core_props
bind wff_core wff_core_props wff_core_props_i (.clk, .rst, .pass_all_multicast, .promiscuous_mode_bit,
	.wake_frame_enable, .wake_clear, .filt_rd, .rx_valid, .rx_sof, .rx_eof, .rx_data, .filt_rvalid, .out_valid,
	.out_eof, .out_data, .out_accept, .out_reject, .out_multicast, .wake_frame_received, .wake_match_filters,
	.remote_wakeup);

// ===== wff_station.sv
// Remote station model sending receive byte streams
`timescale 1ns/1ps
module wff_station (
	// Clock and pacing
	input wire logic clk,
	input wire logic slow,
	// Byte stream
	output logic rx_valid,
	output logic rx_sof,
	output logic rx_eof,
	output logic [7:0] rx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		rx_data = 8'h00;
	end
	// Idle data inverts so a stale byte never looks fresh
	task automatic send(input logic [7:0] f[$]);
		for (int i = 0; i < f.size(); i++) begin
			@(posedge clk) #1;
			rx_valid = 1'b1;
			rx_sof = (i == 0);
			rx_eof = (i == f.size() - 1);
			rx_data = f[i];
			if (slow && !rx_eof) begin
				@(posedge clk) #1;
				rx_valid = 1'b0;
				rx_sof = 1'b0;
				rx_data = ~rx_data;
			end
		end
		@(posedge clk) #1;
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule // wff_station

// ===== wff_core_tb.sv
// Self-checking bench for the wake frame and address filter
`timescale 1ns/1ps
module wff_core_tb import wff_pkg::*;;
	logic clk = 0, rst = 1, slow = 0, pass_all_multicast = 0, promiscuous_mode_bit = 0, inverse_filter = 0;
	logic wake_frame_enable = 0, wake_clear = 0, filt_wr = 0, filt_rd = 0;
	logic [15:0] station_addr_high = 16'h6655;
	logic [31:0] station_addr_low = 32'h4433_2200, filt_wdata = 32'h0000_0000, filt_rdata;
	logic rx_valid, rx_sof, rx_eof, filt_rvalid, out_valid, out_sof, out_eof, out_accept, out_reject;
	logic out_multicast, wake_frame_received, remote_wakeup, fully_operational;
	logic [7:0] rx_data, out_data, wake_match_filters, first;
	logic [31:0] mem [40];
	logic [31:0] rq[$];
	logic [17:0] fq[$];
	logic [17:0] e;
	int fail_count = 0, samples_checked = 0, seed = 34384, nb = 0, wakes = 0;
	wff_core wff_core_i (.clk, .rst, .station_addr_high, .station_addr_low, .pass_all_multicast,
		.promiscuous_mode_bit, .inverse_filter, .wake_frame_enable, .wake_clear, .filt_wr, .filt_rd, .filt_wdata,
		.filt_rdata, .filt_rvalid, .rx_valid, .rx_sof, .rx_eof, .rx_data, .out_valid, .out_sof, .out_eof,
		.out_data, .out_accept, .out_reject, .out_multicast, .wake_frame_received, .wake_match_filters,
		.remote_wakeup, .fully_operational);
	wff_station wff_station_i (.clk, .slow, .rx_valid, .rx_sof, .rx_eof, .rx_data);
	initial forever #50 clk = ~clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****
	// Result watcher
	// ****
	always @(posedge clk) begin
		#2;
		if (filt_rvalid)
			chk(filt_rdata, rq.pop_front());
		if (remote_wakeup)
			wakes++;
		if (out_valid && out_sof)
			first = out_data;
		if (out_valid)
			nb++;
		if (out_eof) begin
			e = fq.pop_front();
			chk({out_accept, out_reject, out_multicast}, {e[17], !e[17], e[16]});
			chk(first, e[15:8]);
			chk(nb, e[7:0]);
			first = 'x;
			nb = 0;
		end
	end
	// Back to back accesses, one word per edge
	task tab(input logic w, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) #1;
			filt_wr = w;
			filt_rd = !w;
			filt_wdata = mem[i % 40];
			if (!w)
				rq.push_back(mem[i % 40]);
		end
		@(posedge clk) #1;
		filt_wr = 0;
		filt_rd = 0;
	endtask
	function automatic logic [15:0] crc(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < 16; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ (i < 8 ? a[7 - i] : b[15 - i])) ? 16'h8005 : 16'h0000);
		return c;
	endfunction
	// Kind 0 station, 1 other physical, 2 multicast, 3 broadcast
	task automatic frame(input int k, input int n, input logic [15:0] p);
		logic [7:0] f[$];
		logic [47:0] sa;
		sa = {station_addr_high, station_addr_low};
		for (int i = 0; i < n; i++)
			f.push_back(k == 3 && i < 6 ? 8'hff : (k == 0 && i < 6 ? sa[8 * i +: 8] : 8'($random(seed))));
		if (k == 1)
			f[0][0] = 1'b0;
		if (k == 2)
			f[0][0] = 1'b1;
		if (n > 14) begin
			f[12] = p[15:8];
			f[14] = p[7:0];
		end
		if (!wake_frame_enable)
			fq.push_back({n >= 6 && (promiscuous_mode_bit || pass_all_multicast && k >= 2 || inverse_filter != (k == 0)),
				k >= 2 && n >= 6, f[0], 8'(n)});
		wff_station_i.send(f);
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		#3_000_000;
		fail_count++;
		end_of_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 0;
		for (int i = 0; i < 40; i++)
			mem[i] = $random(seed);
		tab(1, 40);
		tab(0, 80);
		$display("table test done");
		for (int t = 0; t < 28; t++) begin
			#1 {slow, promiscuous_mode_bit, pass_all_multicast, inverse_filter} = 4'($random(seed));
			frame(t % 4, 8 + t, 16'ha53c);
		end
		promiscuous_mode_bit = 1;
		frame(1, 3, 16'h0000);
		{slow, promiscuous_mode_bit, pass_all_multicast, inverse_filter} = 4'h0;
		$display("filter test done");
		for (int i = 0; i < 40; i++)
			mem[i] = 32'h0000_0000;
		mem[0] = 32'h0000_0005;
		mem[32] = 32'h0000_0001;
		mem[34] = 32'h0000_000c;
		mem[36] = {16'h0000, crc(8'ha5, 8'h3c)};
		tab(1, 40);
		wake_frame_enable = 1;
		frame(0, 20, 16'ha53d);
		frame(1, 20, 16'ha53c);
		chk(fully_operational, 1'b0);
		chk(wake_frame_received, 1'b0);
		chk(wakes, 0);
		frame(0, 20, 16'ha53c);
		chk(wake_frame_received, 1'b1);
		chk(wake_match_filters, 8'h01);
		chk(fully_operational, 1'b1);
		@(posedge clk) #1 wake_clear = 1;
		@(posedge clk) #1 wake_clear = 0;
		wake_frame_enable = 0;
		@(posedge clk) #2;
		chk(wake_frame_received, 1'b0);
		frame(0, 16, 16'h0000);
		chk(wakes, 1);
		$display("wake test done");
		end_of_test;
	end
endmodule // wff_core_tb
